// File: include/ext_int_pkg.sv
// Shared constants, types and decoders for the external interrupt front end
package ext_int_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_SAMPLE_LOW = 8'had;
  localparam logic [7:0] IDX_SAMPLE_GRP = 8'hae;
  localparam logic [7:0] IDX_TRIG_CTRL = 8'hb0;
  localparam logic [7:0] IDX_GRP_CHEN = 8'hb1;
  localparam logic [7:0] IDX_FLAGS = 8'hb2;

  // Values after reset
  localparam logic [7:0] RST_SAMPLE_LOW = 8'h00;
  localparam logic [7:0] RST_SAMPLE_GRP = 8'h00;
  localparam logic [7:0] RST_TRIG_CTRL = 8'h00;
  localparam logic [3:0] RST_GRP_CHEN = 4'h0;
  localparam logic PIN_IDLE_LEVEL = 1'b1;

  // Trigger control field positions
  localparam int TRIG_IN0_BIT = 0;
  localparam int TRIG_IN1_BIT = 1;
  localparam int TRIG_IN2_LSB = 2;
  localparam int TRIG_GRP_LSB = 4;
  localparam int GRP_ENABLE_BIT = 6;

  // Entry timing in machine cycles (one machine cycle per clock)
  localparam logic [3:0] CALL_CYCLES = 4'h7;
  localparam logic [3:0] RETURN_FROM_INTERRUPT_WAIT_CYCLES = 4'h8;
  localparam logic [5:0] RUN_MAX = 6'h3f;

  // Trigger modes of the two-bit fields
  typedef enum logic [1:0] {
    TRIG_LOW = 2'b00,
    TRIG_FALL = 2'b01,
    TRIG_RISE = 2'b10,
    TRIG_BOTH = 2'b11
  } trig_t;

  // Sources in polling order, index 0 polled first
  localparam int N_SRC = 10;
  localparam logic [3:0] SRC_IN0 = 4'h0;
  localparam logic [3:0] SRC_TK = 4'h1;
  localparam logic [3:0] SRC_IN1 = 4'h2;
  localparam logic [3:0] SRC_SERIAL = 4'h3;
  localparam logic [3:0] SRC_T2 = 4'h4;
  localparam logic [3:0] SRC_T4 = 4'h5;
  localparam logic [3:0] SRC_IN2 = 4'h6;
  localparam logic [3:0] SRC_GRP4 = 4'h7;
  localparam logic [3:0] SRC_TWOWIRE = 4'h8;
  localparam logic [3:0] SRC_T3 = 4'h9;

  // Vector per source, in polling order
  localparam logic [15:0] VECTOR_TABLE [N_SRC] = '{16'h0003, 16'h000b, 16'h0013,
    16'h0023, 16'h002b, 16'h003b, 16'h0043, 16'h004b, 16'h0053, 16'h005b};

  // Consecutive samples selected by a two-bit field
  function automatic logic [5:0] sample_count(input logic [1:0] sel);
    unique case (sel)
      2'b00: sample_count = 6'h01;
      2'b01: sample_count = 6'h04;
      2'b10: sample_count = 6'h08;
      2'b11: sample_count = 6'h10;
    endcase
  endfunction

endpackage

// File: include/ext_entry_if.sv
// Request and acknowledge carrier between front end and entry sequencer
`timescale 1ns/10ps
`default_nettype none
interface ext_entry_if;
  logic req_any;
  logic [3:0] req_idx;
  logic ack;
  logic [3:0] ack_idx;
  logic call_busy;
  modport front (output req_any, output req_idx, input ack, input ack_idx, input call_busy);
  modport seq (input req_any, input req_idx, output ack, output ack_idx, output call_busy);
endinterface
`default_nettype wire

// File: design/ext_sample_filter.sv
// Consecutive-sample qualifier for one synchronised interrupt pin
`timescale 1ns/10ps
`default_nettype none
module ext_sample_filter
  import ext_int_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Sample and run length select
  input wire logic smp,
  input wire logic [1:0] count_sel,
  // Qualified events and level
  output logic fall_evt,
  output logic rise_evt,
  output logic low_qual
);

  typedef struct packed {
    logic prev;
    logic armed;
    logic [5:0] run;
    logic fall;
    logic rise;
    logic lowq;
  } filt_t;

  filt_t st_reg;
  filt_t st_next;
  logic [5:0] need;

  assign need = sample_count(count_sel);

  // Run counter and event detection, one sample per cycle
  always_comb
  begin
    st_next = st_reg;
    if (smp != st_reg.prev)
    begin
      st_next.run = 6'h01;
      st_next.armed = 1'b1;
    end
    else if (st_reg.run != RUN_MAX)
    begin
      st_next.run = st_reg.run + 6'h01;
    end
    st_next.prev = smp;
    st_next.fall = st_next.armed && !smp && (st_next.run == need);
    st_next.rise = st_next.armed && smp && (st_next.run == need);
    st_next.lowq = !smp && (st_next.run >= {need[4:0], 1'b0});
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_reg <= '0;
      st_reg.prev <= PIN_IDLE_LEVEL;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign fall_evt = st_reg.fall;
  assign rise_evt = st_reg.rise;
  assign low_qual = st_reg.lowq;

  chk_run_restart: assert property (@(posedge clk_sys) disable iff (srst)
    (smp != st_reg.prev) |=> (st_reg.run == 6'h01))
    else $error("run counter not restarted on a changed sample");

  chk_fall_low_run: assert property (@(posedge clk_sys) disable iff (srst)
    fall_evt |-> !st_reg.prev && !$past(smp) && (st_reg.run == $past(need)))
    else $error("falling event without the selected low run");

endmodule
`default_nettype wire

// File: design/ext_int_entry.sv
// Interrupt entry sequencer: raise timing, blocking waits and the call
`timescale 1ns/10ps
`default_nettype none
module ext_int_entry
  import ext_int_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Core status
  input wire logic instr_final_cycle,
  input wire logic instr_is_return_from_interrupt,
  input wire logic higher_in_progress,
  // Request side
  ext_entry_if.seq bus
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_POLL = 3'b001,
    ST_RAISE = 3'b011,
    ST_CALL = 3'b010,
    ST_RETURN_FROM_INTERRUPT_WAIT = 3'b111
  } entry_state_t;

  typedef struct packed {
    entry_state_t state;
    logic [3:0] cnt;
    logic ack;
    logic [3:0] idx;
    logic [5:0] resp;
  } entry_t;

  entry_t st_reg;
  entry_t st_next;

  localparam int RESP_FLOOR = 8;

  // Next state of the sequencer
  always_comb
  begin
    st_next = st_reg;
    st_next.ack = 1'b0;
    // Response age, held at its top so a long block cannot wrap it
    st_next.resp = (st_reg.state == ST_IDLE) ? 6'h00 : st_reg.resp;
    if (st_reg.state != ST_IDLE && st_reg.resp != 6'h3f)
    begin
      st_next.resp = st_reg.resp + 6'h01;
    end
    unique case (st_reg.state)
      ST_IDLE:
      begin
        if (bus.req_any)
        begin
          st_next.state = ST_POLL;
        end
      end
      ST_POLL:
      begin
        st_next.state = ST_RAISE;
      end
      ST_RAISE:
      begin
        if (!bus.req_any)
        begin
          st_next.state = ST_IDLE;
        end
        else if (instr_is_return_from_interrupt && !instr_final_cycle)
        begin
          st_next.state = ST_RETURN_FROM_INTERRUPT_WAIT;
          st_next.cnt = RETURN_FROM_INTERRUPT_WAIT_CYCLES;
        end
        else if (instr_final_cycle && !higher_in_progress && !instr_is_return_from_interrupt)
        begin
          st_next.state = ST_CALL;
          st_next.cnt = CALL_CYCLES;
          st_next.ack = 1'b1;
          st_next.idx = bus.req_idx;
        end
      end
      ST_RETURN_FROM_INTERRUPT_WAIT:
      begin
        st_next.cnt = st_reg.cnt - 4'h1;
        if (st_reg.cnt == 4'h1)
        begin
          st_next.state = ST_RAISE;
        end
      end
      ST_CALL:
      begin
        st_next.cnt = st_reg.cnt - 4'h1;
        if (st_reg.cnt == 4'h1)
        begin
          st_next.state = ST_IDLE;
        end
      end
      default:
      begin
        st_next.state = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign bus.ack = st_reg.ack;
  assign bus.ack_idx = st_reg.idx;
  assign bus.call_busy = (st_reg.state == ST_CALL);

  sequence s_call_body;
    bus.call_busy [*7] ##1 !bus.call_busy;
  endsequence

  sequence s_return_from_interrupt_hold;
    (st_reg.state == ST_RETURN_FROM_INTERRUPT_WAIT) [*8] ##1 (st_reg.state == ST_RAISE);
  endsequence

  chk_call_seven: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(bus.call_busy) |-> bus.ack ##0 s_call_body)
    else $error("call did not last seven cycles");

  chk_raise_third: assert property (@(posedge clk_sys) disable iff (srst)
    (st_reg.state == ST_IDLE && bus.req_any) |=> (st_reg.state == ST_POLL)
    ##1 (st_reg.state == ST_RAISE))
    else $error("interrupt not raised in the third cycle");

  chk_return_from_interrupt_wait: assert property (@(posedge clk_sys) disable iff (srst)
    (st_reg.state == ST_RAISE && bus.req_any && instr_is_return_from_interrupt && !instr_final_cycle)
    |=> s_return_from_interrupt_hold)
    else $error("wait after return was not eight cycles");

  chk_resp_floor: assert property (@(posedge clk_sys) disable iff (srst)
    (bus.call_busy && st_reg.cnt == 4'h1) |-> (st_reg.resp >= RESP_FLOOR))
    else $error("response shorter than ten cycles");

endmodule
`default_nettype wire

// File: design/ext_interrupt_input_logic.sv
// External interrupt front end: APB registers, pin filters, flags, polling
//
// How it works
// - An acknowledged request starts a hardware call lasting exactly seven cycles.
// - Interrupt is raised in the third cycle after recognition; blocked ones pend.
// - A return instruction not in its final cycle adds eight waiting cycles.
// - Single-source response lies between ten and thirty-seven cycles.
// - Four external inputs; inputs zero to two own vectors, group four shares one.
// - With trigger bit clear, inputs zero and one request on a low level.
// - Edge flag sets after a high sample then the selected run of lows.
// - Each pin is sampled once per cycle; sources hold levels that long.
// - Edge flags of inputs zero to two clear when their call starts.
// - Level requests need twice the sample count and must be held.
// - Level-mode flags follow the pin; a held request interrupts again.
// - Two-bit sample fields select 1, 4, 8 or 16 samples.
// - A request during idle or power-down wakes the processor.
// - Each source uses its fixed vector address.
// - Simultaneous requests are polled in a fixed order.
// - Inputs two and four have low, falling, rising or both-edge modes.
// - Trigger bit set on inputs zero and one selects falling edges.
// - Every group four channel has its own enable bit.
`timescale 1ns/10ps
`default_nettype none
module ext_interrupt_input_logic
  import ext_int_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External request pins
  input wire logic ext_req_in_zero,
  input wire logic ext_req_in_one,
  input wire logic ext_req_in_two,
  input wire logic [3:0] ext_req_group_four,
  // Requests of the other sources, already gated by their owners
  input wire logic req_touch_key,
  input wire logic req_serial,
  input wire logic req_timer_two,
  input wire logic req_timer_four,
  input wire logic req_two_wire,
  input wire logic req_timer_three,
  // Core status
  input wire logic instr_final_cycle,
  input wire logic instr_is_return_from_interrupt,
  input wire logic higher_in_progress,
  input wire logic core_idle,
  input wire logic core_power_down,
  // Entry outputs
  output logic hw_call_active,
  output logic hw_call_start,
  output logic [15:0] vector_addr,
  output logic wake_up
);

  localparam int N_PIN = 7;

  typedef struct packed {
    logic [N_PIN-1:0] sync1;
    logic [N_PIN-1:0] sync2;
    logic [7:0] sample_ctrl_low;
    logic [7:0] sample_ctrl_group4;
    logic [7:0] trig_ctrl;
    logic [3:0] grp_chen;
    logic [N_PIN-1:0] flags;
    logic [31:0] rdata;
    logic slverr;
    logic [15:0] vector;
    logic wake;
  } front_t;

  front_t st_reg;
  front_t st_next;

  ext_entry_if entry_bus ();

  logic [1:0] sel [N_PIN];
  trig_t pin_mode [N_PIN];
  logic [N_PIN-1:0] fall_evt;
  logic [N_PIN-1:0] rise_evt;
  logic [N_PIN-1:0] low_qual;
  logic [N_PIN-1:0] edge_evt;
  logic [N_SRC-1:0] req_vec;
  logic grp_req;
  logic setup_phase;
  logic wr_access;

  // Register hit for a printed index
  function automatic logic reg_hit(input logic [11:0] addr, input logic [7:0] idx);
    reg_hit = (addr == {2'b00, idx, 2'b00});
  endfunction

  // Event chosen by the trigger mode
  function automatic logic mode_event(input trig_t m, input logic f, input logic r);
    unique case (m)
      TRIG_LOW: mode_event = 1'b0;
      TRIG_FALL: mode_event = f;
      TRIG_RISE: mode_event = r;
      TRIG_BOTH: mode_event = f | r;
    endcase
  endfunction

  // First pending source in polling order
  function automatic logic [3:0] first_req(input logic [N_SRC-1:0] v);
    first_req = 4'h0;
    for (int k = N_SRC - 1; k >= 0; k--)
    begin
      if (v[k])
      begin
        first_req = 4'(k);
      end
    end
  endfunction

  // Mode and sample select per pin
  assign pin_mode[0] = st_reg.trig_ctrl[TRIG_IN0_BIT] ? TRIG_FALL : TRIG_LOW;
  assign pin_mode[1] = st_reg.trig_ctrl[TRIG_IN1_BIT] ? TRIG_FALL : TRIG_LOW;
  assign pin_mode[2] = trig_t'(st_reg.trig_ctrl[TRIG_IN2_LSB +: 2]);
  assign sel[0] = st_reg.sample_ctrl_low[1:0];
  assign sel[1] = st_reg.sample_ctrl_low[3:2];
  assign sel[2] = st_reg.sample_ctrl_low[5:4];

  // Filters; the group four channels share one trigger mode
  genvar gi;
  generate
    for (gi = 0; gi < N_PIN; gi++)
    begin : g_pin
      if (gi >= 3)
      begin : g_grp
        assign pin_mode[gi] = trig_t'(st_reg.trig_ctrl[TRIG_GRP_LSB +: 2]);
        assign sel[gi] = st_reg.sample_ctrl_group4[2*(gi-3) +: 2];
      end
      ext_sample_filter u_filt (
        .clk_sys(clk_sys),
        .srst(srst),
        .smp(st_reg.sync2[gi]),
        .count_sel(sel[gi]),
        .fall_evt(fall_evt[gi]),
        .rise_evt(rise_evt[gi]),
        .low_qual(low_qual[gi])
      );
      assign edge_evt[gi] = mode_event(pin_mode[gi], fall_evt[gi], rise_evt[gi]);
    end
  endgenerate

  // Request vector in polling order
  assign grp_req = st_reg.trig_ctrl[GRP_ENABLE_BIT]
    && |(st_reg.flags[6:3] & st_reg.grp_chen);
  assign req_vec = {req_timer_three, req_two_wire, grp_req, st_reg.flags[2],
    req_timer_four, req_timer_two, req_serial, st_reg.flags[1], req_touch_key,
    st_reg.flags[0]};
  assign entry_bus.req_any = |req_vec;
  assign entry_bus.req_idx = first_req(req_vec);

  // APB phases
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite;

  // Next state: synchronisers, flags, registers, read data
  always_comb
  begin
    st_next = st_reg;
    st_next.sync1 = {ext_req_group_four, ext_req_in_two, ext_req_in_one, ext_req_in_zero};
    st_next.sync2 = st_reg.sync1;
    // Flags: level mode tracks the pin, edge mode is sticky
    for (int i = 0; i < N_PIN; i++)
    begin
      if (pin_mode[i] == TRIG_LOW)
      begin
        st_next.flags[i] = low_qual[i];
      end
      else
      begin
        if (wr_access && pstrb[0] && reg_hit(paddr, IDX_FLAGS))
        begin
          if (i < 3 && pwdata[i])
          begin
            st_next.flags[i] = 1'b0;
          end
          if (i >= 3 && pwdata[i + 1])
          begin
            st_next.flags[i] = 1'b0;
          end
        end
        if (i < 3 && entry_bus.ack && entry_bus.ack_idx == (i == 0 ? SRC_IN0 :
          (i == 1 ? SRC_IN1 : SRC_IN2)))
        begin
          st_next.flags[i] = 1'b0;
        end
        if (edge_evt[i])
        begin
          st_next.flags[i] = 1'b1;
        end
      end
    end
    // Register writes, low byte only
    if (wr_access && pstrb[0])
    begin
      if (reg_hit(paddr, IDX_SAMPLE_LOW))
      begin
        st_next.sample_ctrl_low = {2'b00, pwdata[5:0]};
      end
      if (reg_hit(paddr, IDX_SAMPLE_GRP))
      begin
        st_next.sample_ctrl_group4 = pwdata[7:0];
      end
      if (reg_hit(paddr, IDX_TRIG_CTRL))
      begin
        st_next.trig_ctrl = {1'b0, pwdata[6:0]};
      end
      if (reg_hit(paddr, IDX_GRP_CHEN))
      begin
        st_next.grp_chen = pwdata[3:0];
      end
    end
    // Read data and error latched in the setup phase
    if (setup_phase)
    begin
      st_next.rdata = 32'h0000_0000;
      st_next.slverr = 1'b0;
      if (reg_hit(paddr, IDX_SAMPLE_LOW))
      begin
        st_next.rdata[7:0] = st_reg.sample_ctrl_low;
      end
      else if (reg_hit(paddr, IDX_SAMPLE_GRP))
      begin
        st_next.rdata[7:0] = st_reg.sample_ctrl_group4;
      end
      else if (reg_hit(paddr, IDX_TRIG_CTRL))
      begin
        st_next.rdata[7:0] = st_reg.trig_ctrl;
      end
      else if (reg_hit(paddr, IDX_GRP_CHEN))
      begin
        st_next.rdata[3:0] = st_reg.grp_chen;
      end
      else if (reg_hit(paddr, IDX_FLAGS))
      begin
        st_next.rdata[7:0] = {st_reg.flags[6:3], 1'b0, st_reg.flags[2:0]};
      end
      else
      begin
        st_next.slverr = 1'b1;
      end
    end
    // Vector captured at the start of the call
    if (entry_bus.ack)
    begin
      st_next.vector = VECTOR_TABLE[entry_bus.ack_idx];
    end
    st_next.wake = (core_idle || core_power_down) && entry_bus.req_any;
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_reg <= '0;
      st_reg.sync1 <= {N_PIN{PIN_IDLE_LEVEL}};
      st_reg.sync2 <= {N_PIN{PIN_IDLE_LEVEL}};
      st_reg.sample_ctrl_low <= RST_SAMPLE_LOW;
      st_reg.sample_ctrl_group4 <= RST_SAMPLE_GRP;
      st_reg.trig_ctrl <= RST_TRIG_CTRL;
      st_reg.grp_chen <= RST_GRP_CHEN;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Entry sequencer
  ext_int_entry u_entry (
    .clk_sys(clk_sys),
    .srst(srst),
    .instr_final_cycle(instr_final_cycle),
    .instr_is_return_from_interrupt(instr_is_return_from_interrupt),
    .higher_in_progress(higher_in_progress),
    .bus(entry_bus)
  );

  // Outputs
  assign prdata = st_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = st_reg.slverr && psel && penable;
  assign hw_call_active = entry_bus.call_busy;
  assign hw_call_start = entry_bus.ack;
  assign vector_addr = st_reg.vector;
  assign wake_up = st_reg.wake;

  chk_hw_flag_clear: assert property (@(posedge clk_sys) disable iff (srst)
    (entry_bus.ack && entry_bus.ack_idx == SRC_IN1 && pin_mode[1] == TRIG_FALL
    && !edge_evt[1]) |=> !st_reg.flags[1])
    else $error("edge flag of input one not cleared at entry");

  chk_group_kept: assert property (@(posedge clk_sys) disable iff (srst)
    (entry_bus.ack && entry_bus.ack_idx == SRC_GRP4 && pin_mode[3] != TRIG_LOW
    && !wr_access) |=> ((~st_reg.flags & $past(st_reg.flags) & 7'h78) == 7'h00))
    else $error("group channel flag cleared by entry");

  chk_level_track: assert property (@(posedge clk_sys) disable iff (srst)
    (pin_mode[1] == TRIG_LOW) |=> (st_reg.flags[1] == $past(low_qual[1])))
    else $error("level flag does not follow the pin");

  chk_poll_first: assert property (@(posedge clk_sys) disable iff (srst)
    entry_bus.req_any |-> req_vec[entry_bus.req_idx]
    && ((req_vec & ((10'h001 << entry_bus.req_idx) - 10'h001)) == 10'h000))
    else $error("polling order broken");

  chk_group_gate: assert property (@(posedge clk_sys) disable iff (srst)
    (!st_reg.trig_ctrl[GRP_ENABLE_BIT] || st_reg.grp_chen == 4'h0) |-> !grp_req)
    else $error("group four request without enable");

  chk_wake_req: assert property (@(posedge clk_sys) disable iff (srst)
    (core_idle && entry_bus.req_any) |=> wake_up)
    else $error("no wake on request during idle");

endmodule
`default_nettype wire

// File: tb/ext_src_model.sv
// Behavioural external request sources driving the interrupt pins
`timescale 1ns/10ps
`default_nettype none
module ext_src_model
(
  // Clock
  input wire logic clk_sys,
  // Pins, pulled up while idle
  output logic [6:0] pins
);
  initial pins = 7'h7f;

  // Drive one pin and hold the level for n machine cycles
  task automatic hold(input int idx, input logic lvl, input int n);
    pins[idx] <= lvl;
    repeat (n) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the external interrupt front end
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ext_int_pkg::*;
  logic clk_sys = 0;
  logic srst = 1;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, err;
  logic [6:0] pins;
  logic [5:0] oth = 6'h00;
  logic final_c = 0, return_from_interrupt = 0, idle = 0, hip = 0, pdn = 0;
  logic hw_call_active, hw_call_start, wake_up;
  logic [15:0] vector_addr;
  logic [7:0] d;
  int n_errors = 0, checked = 0, k;
  logic [15:0] vtab [6] = '{16'h000b, 16'h0023, 16'h002b, 16'h003b, 16'h0053, 16'h005b};

  always #5 clk_sys = ~clk_sys;

  ext_src_model src_u (.clk_sys(clk_sys), .pins(pins));

  ext_interrupt_input_logic dut_u (.clk_sys(clk_sys), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_req_in_zero(pins[0]),
    .ext_req_in_one(pins[1]), .ext_req_in_two(pins[2]), .ext_req_group_four(pins[6:3]),
    .req_touch_key(oth[0]), .req_serial(oth[1]), .req_timer_two(oth[2]),
    .req_timer_four(oth[3]), .req_two_wire(oth[4]), .req_timer_three(oth[5]),
    .instr_final_cycle(final_c), .instr_is_return_from_interrupt(return_from_interrupt), .higher_in_progress(hip),
    .core_idle(idle), .core_power_down(pdn), .hw_call_active(hw_call_active),
    .hw_call_start(hw_call_start), .vector_addr(vector_addr), .wake_up(wake_up));

  // Compare one value and count it
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Wait for a call, check its length and vector
  task automatic call_chk(input logic [15:0] v);
    int i, cnt;
    i = 0;
    while (hw_call_start !== 1'b1 && i < 80)
    begin
      @(posedge clk_sys);
      i++;
    end
    oth <= 6'h00;
    cnt = 0;
    while (hw_call_active === 1'b1 && cnt < 20)
    begin
      cnt++;
      @(posedge clk_sys);
    end
    chk(cnt, 7);
    chk(vector_addr, v);
  endtask

  task automatic wrap_up;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #200us;
    n_errors++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(45683));
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    // Reset values and unmapped access
    apb(0, 12'h2b4, 0); chk(rd[7:0], 8'h00);
    apb(0, 12'h2b8, 0); chk(rd[7:0], 8'h00);
    apb(0, 12'h2f0, 0); chk(err, 1'b1);
    // Random sample fields read back
    repeat (4)
    begin
      d = 8'($urandom);
      apb(1, 12'h2b8, d); apb(0, 12'h2b8, 0); chk(rd[7:0], d);
      apb(1, 12'h2b4, d); apb(0, 12'h2b4, 0); chk(rd[5:0], d[5:0]);
    end
    apb(1, 12'h2b4, 8'h04);
    apb(1, 12'h2b8, 8'h00);
    // Level request on input zero, held so it fires twice
    final_c <= 1'b1;
    src_u.hold(0, 1'b0, 1);
    call_chk(16'h0003);
    call_chk(16'h0003);
    src_u.hold(0, 1'b1, 10);
    // Other sources alone, then all together
    for (k = 0; k < 6; k++)
    begin
      oth <= 6'(1 << k);
      call_chk(vtab[k]);
      repeat (3) @(posedge clk_sys);
    end
    oth <= 6'h3f;
    call_chk(16'h000b);
    repeat (3) @(posedge clk_sys);
    // Falling edge on input one with four samples; a short low run is ignored
    final_c <= 1'b0;
    apb(1, 12'h2c0, 8'h02);
    src_u.hold(1, 1'b0, 2);
    src_u.hold(1, 1'b1, 12);
    apb(0, 12'h2c8, 0); chk(rd[1], 1'b0);
    src_u.hold(1, 1'b0, 12);
    apb(0, 12'h2c8, 0); chk(rd[1], 1'b1);
    final_c <= 1'b1;
    call_chk(16'h0013);
    apb(0, 12'h2c8, 0); chk(rd[1], 1'b0);
    src_u.hold(1, 1'b1, 2);
    // Group four channel two, falling edge, flag kept after entry
    apb(1, 12'h2c4, 8'h04);
    apb(1, 12'h2c0, 8'h50);
    src_u.hold(5, 1'b0, 2);
    call_chk(16'h004b);
    apb(0, 12'h2c8, 0); chk(rd[6], 1'b1);
    apb(1, 12'h2c8, 8'h40);
    apb(0, 12'h2c8, 0); chk(rd[6], 1'b0);
    src_u.hold(5, 1'b1, 2);
    // Input two on both edges: each edge requests once
    apb(1, 12'h2c0, 8'h0c);
    src_u.hold(2, 1'b0, 4);
    call_chk(16'h0043);
    src_u.hold(2, 1'b1, 1);
    call_chk(16'h0043);
    // Return instruction outside its final cycle adds waits; idle core wakes
    apb(1, 12'h2c4, 8'h00);
    final_c <= 1'b0;
    return_from_interrupt <= 1'b1;
    idle <= 1'b1;
    oth <= 6'h20;
    k = 0;
    repeat (12)
    begin
      @(posedge clk_sys);
      if (hw_call_start === 1'b1)
        k++;
    end
    chk(k, 0);
    chk(wake_up, 1'b1);
    // Higher service in progress keeps it pending; power-down wakes
    return_from_interrupt <= 1'b0;
    idle <= 1'b0;
    final_c <= 1'b1;
    hip <= 1'b1;
    pdn <= 1'b1;
    k = 0;
    repeat (12)
    begin
      @(posedge clk_sys);
      if (hw_call_start === 1'b1)
        k++;
    end
    chk(k, 0);
    chk(wake_up, 1'b1);
    hip <= 1'b0;
    pdn <= 1'b0;
    call_chk(16'h005b);
    wrap_up();
  end
endmodule
`default_nettype wire
